//--- core/prd_pkg.sv
// constants for the reference divider and switchover control block
package prd_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_LOOP_CTRL = 10'h010;
  localparam logic [9:0]  IDX_DIV_LOW   = 10'h011;
  localparam logic [9:0]  IDX_DIV_HIGH  = 10'h012;
  localparam logic [9:0]  IDX_DET_PULSE = 10'h017;
  localparam logic [9:0]  IDX_MON_CFG   = 10'h01B;
  localparam logic [9:0]  IDX_REF_CTRL  = 10'h01C;
  localparam logic [9:0]  IDX_PUMP_CUR  = 10'h01D;
  localparam logic [9:0]  IDX_CNT_RST   = 10'h01E;
  localparam logic [9:0]  IDX_STATUS    = 10'h01F;
  localparam logic [9:0]  IDX_UPDATE    = 10'h232;
  localparam logic [7:0]  UPDATE_CMD    = 8'h01;
  // reset values, every reference buffer off
  localparam logic [7:0]  RST_REG       = 8'h00;
  // loop control fields
  localparam int          LC_POLARITY   = 7;
  localparam int          LC_MODE_LSB   = 4;
  localparam logic [1:0]  LC_PWR_ON     = 2'h0;
  // pump mode codes
  localparam logic [2:0]  PM_HIZ        = 3'h0;
  localparam logic [2:0]  PM_UP         = 3'h1;
  localparam logic [2:0]  PM_DOWN       = 3'h2;
  localparam logic [2:0]  PM_NORMAL     = 3'h3;
  // reference control fields
  localparam int          RC_DIFF       = 0;
  localparam int          RC_PRI_EN     = 1;
  localparam int          RC_SEC_EN     = 2;
  localparam int          RC_MAN_SEC    = 3;
  localparam int          RC_USE_PIN    = 4;
  localparam int          RC_AUTO       = 5;
  localparam int          RC_PREF_SEC   = 6;
  localparam int          RC_NO_DEGL    = 7;
  // counter reset fields
  localparam int          CR_REF        = 0;
  localparam int          CR_SHARED     = 1;
  localparam int          CR_SYNC_EN    = 2;
  // monitor source codes
  localparam logic [3:0]  MS_LOW        = 4'h0;
  localparam logic [3:0]  MS_HIGH       = 4'h1;
  localparam logic [3:0]  MS_PRI_BAD    = 4'h7;
  localparam logic [3:0]  MS_SEC_BAD    = 4'h8;
  localparam logic [3:0]  MS_SEC_SEL    = 4'hF;
  // timing
  localparam int          DIV_WIDTH     = 14;
  localparam int          LOSS_CYCLES   = 64;
  localparam int          CLK_MHZ       = 125;
  localparam int          ABL_STEP_NS   = 8;
  localparam int          ABL_STEP_CYC  = (ABL_STEP_NS * CLK_MHZ + 999) / 1000;
  // bus answer states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } prd_bus_type;
endpackage : prd_pkg

//--- core/prd_ref_divider.sv
// reference divider counter, one tick per programmed count of edges
`timescale 1ns/1ps
module prd_ref_divider
  import prd_pkg::*;
#(
  parameter int WIDTH = DIV_WIDTH
)
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  // control
  input  wire logic             edge_i,
  input  wire logic             clear_i,
  input  wire logic [WIDTH-1:0] divide_i,
  // divided output
  output logic                  tick_o
);
  // remaining edges until the next tick
  logic [WIDTH-1:0] count_q;

  initial
  begin
    if (WIDTH < 2 || WIDTH > 16)
      $error("divider width out of range");
  end

  // count down, reload on terminal count
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      count_q <= '0;
      tick_o  <= 1'b0;
    end
    else if (clear_i)
    begin
      // held while any reset source stays set
      count_q <= '0;
      tick_o  <= 1'b0;
    end
    else if (edge_i)
    begin
      if (count_q <= WIDTH'(1))
      begin
        // zero and one both divide by one
        count_q <= divide_i;
        tick_o  <= 1'b1;
      end
      else
      begin
        count_q <= count_q - WIDTH'(1);
        tick_o  <= 1'b0;
      end
    end
    else
      tick_o <= 1'b0;
  end
endmodule : prd_ref_divider

//--- core/prd_ctrl.sv
// loop reference control: registers, switchover, divider, detector
//
// Functional notes
// - fourteen-bit divider, value 0 to 16383
// - zero or one both divide by one
// - divided reference feeds detector input
// - two-bit antibacklash width field
// - pump mode: high-z, normal, up, down
// - pump current in eight steps
// - differential or dual single-ended by register
// - all reference buffers off after reset
// - differential buffer off unless selected, powered
// - single-ended buffers off by three causes
// - auto and manual selection single-ended
// - manual selection by register or pin
// - monitor high while primary invalid
// - revert to primary once valid again
// - status pin alternative, secondary preferable
// - deglitch blocks misaligned edges on switch
// - no nonrevertive automatic switching
// - divider reset: own, shared, sync
// - reset bits hold until cleared
// - settings active after update command, counter resets at once
// - polarity bit swaps detector outputs
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module prd_ctrl
  import prd_pkg::*;
#(
  parameter int LOSS_CNT = LOSS_CYCLES
)
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // avalon-mm slave
  input  wire logic [11:0] address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // reference pins and feedback
  input  wire logic        primary_reference_i,
  input  wire logic        secondary_reference_i,
  input  wire logic        ref_select_i,
  input  wire logic        sync_i,
  input  wire logic        fb_div_tick_i,
  // buffer enables
  output logic             diff_buf_en_o,
  output logic             primary_buf_en_o,
  output logic             secondary_buf_en_o,
  // monitor and status pins
  output logic             ref_monitor_out_o,
  output logic             status_out_o,
  // pump and counter controls
  output logic             pump_up_o,
  output logic             pump_down_o,
  output logic             pump_hiz_o,
  output logic [2:0]       pump_current_o,
  output logic             fb_counter_rst_o
);
  initial
  begin
    if (LOSS_CNT < 2 || LOSS_CNT > 65535)
      $error("loss count out of range");
  end

  // rising edge of a sampled level
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  // monitor pin source decode
  function automatic logic mon_src(input logic [3:0] code, input logic pbad,
                                   input logic sbad, input logic ssel);
    case (code)
      MS_HIGH:    mon_src = 1'b1;
      MS_PRI_BAD: mon_src = pbad;
      MS_SEC_BAD: mon_src = sbad;
      MS_SEC_SEL: mon_src = ssel;
      default:    mon_src = 1'b0;
    endcase
  endfunction : mon_src

  // staged and active register copies
  logic [7:0]  stg_loop_q, stg_lo_q, stg_hi_q, stg_det_q, stg_mon_q;
  logic [7:0]  stg_ref_q, stg_cur_q;
  logic [7:0]  act_loop_q, act_det_q, act_mon_q, act_ref_q, act_cur_q;
  logic [13:0] act_div_q;
  logic [2:0]  cnt_rst_q;          // counter resets, not self-clearing
  // bus state
  prd_bus_type bus_q;
  logic        req;
  logic        wr_go;
  logic [9:0]  idx;
  logic [7:0]  wbyte;
  // reference sampling and validity
  logic [1:0]  ref_q, ref_prev_q;
  logic [1:0]  ref_bad_q;
  logic [15:0] loss_q [2];
  logic        sel_sec_q, sel_sec_d;
  logic        hold_q;
  logic        sel_edge;
  logic        ref_div_tick;
  logic        div_clear;
  // detector state
  logic        up_q, dn_q;
  logic [7:0]  abl_q;
  // decoded active fields
  logic        loop_on, diff_mode, auto_on, pref_bad;

  assign req   = read_i | write_i;
  assign idx   = address_i[11:2];
  assign wbyte = writedata_i[7:0];
  assign wr_go = write_i && bus_q == BUS_ACK;

  assign loop_on   = act_loop_q[1:0] == LC_PWR_ON;
  assign diff_mode = act_ref_q[RC_DIFF];
  assign auto_on   = act_ref_q[RC_AUTO];
  assign pref_bad  = act_ref_q[RC_PREF_SEC] ? ref_bad_q[1] : ref_bad_q[0];

  // bus handshake: wait one cycle, then answer for one cycle
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_q         <= BUS_IDLE;
      waitrequest_o <= 1'b1;
    end
    else if (bus_q == BUS_IDLE && req)
    begin
      bus_q         <= BUS_ACK;
      waitrequest_o <= 1'b0;
    end
    else
    begin
      bus_q         <= BUS_IDLE;
      waitrequest_o <= 1'b1;
    end
  end

  // read data latched as the answer is raised
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      readdata_o <= '0;
    else if (bus_q == BUS_IDLE && read_i)
    begin
      case (idx)
        IDX_LOOP_CTRL: readdata_o <= {24'h0, stg_loop_q};
        IDX_DIV_LOW:   readdata_o <= {24'h0, stg_lo_q};
        IDX_DIV_HIGH:  readdata_o <= {24'h0, stg_hi_q};
        IDX_DET_PULSE: readdata_o <= {24'h0, stg_det_q};
        IDX_MON_CFG:   readdata_o <= {24'h0, stg_mon_q};
        IDX_REF_CTRL:  readdata_o <= {24'h0, stg_ref_q};
        IDX_PUMP_CUR:  readdata_o <= {24'h0, stg_cur_q};
        IDX_CNT_RST:   readdata_o <= {29'h0, cnt_rst_q};
        IDX_STATUS:    readdata_o <= {28'h0, hold_q, sel_sec_q, ~ref_bad_q};
        default:       readdata_o <= '0;   // unmapped reads as zero
      endcase
    end
  end

  // staged registers written at the answer edge
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stg_loop_q <= RST_REG;
      stg_lo_q   <= RST_REG;
      stg_hi_q   <= RST_REG;
      stg_det_q  <= RST_REG;
      stg_mon_q  <= RST_REG;
      stg_ref_q  <= RST_REG;
      stg_cur_q  <= RST_REG;
    end
    else if (wr_go)
    begin
      case (idx)
        IDX_LOOP_CTRL: stg_loop_q <= wbyte;
        IDX_DIV_LOW:   stg_lo_q   <= wbyte;
        IDX_DIV_HIGH:  stg_hi_q   <= {2'h0, wbyte[5:0]};
        IDX_DET_PULSE: stg_det_q  <= {6'h0, wbyte[1:0]};
        IDX_MON_CFG:   stg_mon_q  <= wbyte;
        IDX_REF_CTRL:  stg_ref_q  <= wbyte;
        IDX_PUMP_CUR:  stg_cur_q  <= {5'h0, wbyte[2:0]};
        default:       stg_loop_q <= stg_loop_q;
      endcase
    end
  end

  // counter reset bits act at once and stay until cleared
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_rst_q <= '0;
    else if (wr_go && idx == IDX_CNT_RST)
      cnt_rst_q <= wbyte[2:0];
  end

  // update command moves staged settings into use
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      act_loop_q <= RST_REG;
      act_div_q  <= '0;
      act_det_q  <= RST_REG;
      act_mon_q  <= RST_REG;
      act_ref_q  <= RST_REG;
      act_cur_q  <= RST_REG;
    end
    else if (wr_go && idx == IDX_UPDATE && wbyte == UPDATE_CMD)
    begin
      act_loop_q <= stg_loop_q;
      act_div_q  <= {stg_hi_q[5:0], stg_lo_q};
      act_det_q  <= stg_det_q;
      act_mon_q  <= stg_mon_q;
      act_ref_q  <= stg_ref_q;
      act_cur_q  <= stg_cur_q;
    end
  end

  // sample pins and track edges
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ref_q      <= '0;
      ref_prev_q <= '0;
    end
    else
    begin
      ref_q      <= {secondary_reference_i, primary_reference_i};
      ref_prev_q <= ref_q;
    end
  end

  // loss detect: no rising edge within the loss count
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      loss_q[0] <= '0;
      loss_q[1] <= '0;
      ref_bad_q <= 2'h3;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rise(ref_q[i], ref_prev_q[i]))
        begin
          loss_q[i]    <= '0;
          ref_bad_q[i] <= 1'b0;
        end
        else if (loss_q[i] >= 16'(LOSS_CNT - 1))
          ref_bad_q[i] <= 1'b1;
        else
          loss_q[i] <= loss_q[i] + 16'h1;
      end
    end
  end

  // reference choice: auto always reverts to preferred
  always_comb
  begin
    if (diff_mode)
      sel_sec_d = 1'b0;
    else if (auto_on)
      sel_sec_d = act_ref_q[RC_PREF_SEC] ^ pref_bad;
    else if (act_ref_q[RC_USE_PIN])
      sel_sec_d = ref_select_i;
    else
      sel_sec_d = act_ref_q[RC_MAN_SEC];
  end

  // selection register and switchover deglitch hold
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sel_sec_q <= 1'b0;
      hold_q    <= 1'b0;
    end
    else
    begin
      sel_sec_q <= sel_sec_d;
      if (sel_sec_d != sel_sec_q && !act_ref_q[RC_NO_DEGL])
        hold_q <= 1'b1;
      else if (act_ref_q[RC_NO_DEGL] || rise(ref_q[sel_sec_q], ref_prev_q[sel_sec_q]))
        hold_q <= 1'b0;
    end
  end

  // edges reaching the divider, blocked while holding
  assign sel_edge = loop_on && !hold_q && sel_sec_d == sel_sec_q
                    && rise(ref_q[sel_sec_q], ref_prev_q[sel_sec_q]);

  // own, shared and sync resets of the divider
  assign div_clear = cnt_rst_q[CR_REF] || cnt_rst_q[CR_SHARED]
                     || (cnt_rst_q[CR_SYNC_EN] && sync_i);

  prd_ref_divider #(
    .WIDTH    (DIV_WIDTH)
  ) u_div (
    .clock_i  (clock_i),
    .sys_rst_i(sys_rst_i),
    .edge_i   (sel_edge),
    .clear_i  (div_clear),
    .divide_i (act_div_q),
    .tick_o   (ref_div_tick)
  );

  // buffer power, monitor pins and feedback counter reset
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      diff_buf_en_o      <= 1'b0;
      primary_buf_en_o   <= 1'b0;
      secondary_buf_en_o <= 1'b0;
      ref_monitor_out_o  <= 1'b0;
      status_out_o       <= 1'b0;
      fb_counter_rst_o   <= 1'b0;
      pump_current_o     <= '0;
    end
    else
    begin
      diff_buf_en_o      <= loop_on && diff_mode;
      primary_buf_en_o   <= loop_on && !diff_mode && act_ref_q[RC_PRI_EN];
      secondary_buf_en_o <= loop_on && !diff_mode && act_ref_q[RC_SEC_EN];
      ref_monitor_out_o  <= mon_src(act_mon_q[3:0], ref_bad_q[0], ref_bad_q[1], sel_sec_q);
      status_out_o       <= mon_src(act_mon_q[7:4], ref_bad_q[0], ref_bad_q[1], sel_sec_q);
      fb_counter_rst_o   <= cnt_rst_q[CR_SHARED] || (cnt_rst_q[CR_SYNC_EN] && sync_i);
      pump_current_o     <= act_cur_q[2:0];
    end
  end

  // detector: divided reference against divided feedback
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      abl_q <= '0;
    end
    else if (up_q && dn_q)
    begin
      // both set: hold for the antibacklash width, then clear
      if (abl_q >= 8'((act_det_q[1:0] + 2'h1) * ABL_STEP_CYC))
      begin
        up_q  <= 1'b0;
        dn_q  <= 1'b0;
        abl_q <= '0;
      end
      else
        abl_q <= abl_q + 8'h1;
    end
    else
    begin
      up_q <= up_q | ref_div_tick;
      dn_q <= dn_q | fb_div_tick_i;
    end
  end

  // pump drive by mode and polarity
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pump_up_o   <= 1'b0;
      pump_down_o <= 1'b0;
      pump_hiz_o  <= 1'b1;
    end
    else
    begin
      case (act_loop_q[LC_MODE_LSB +: 3])
        PM_UP:
        begin
          pump_up_o   <= 1'b1;
          pump_down_o <= 1'b0;
          pump_hiz_o  <= 1'b0;
        end
        PM_DOWN:
        begin
          pump_up_o   <= 1'b0;
          pump_down_o <= 1'b1;
          pump_hiz_o  <= 1'b0;
        end
        PM_NORMAL:
        begin
          // negative slope swaps the directions
          pump_up_o   <= act_loop_q[LC_POLARITY] ? dn_q : up_q;
          pump_down_o <= act_loop_q[LC_POLARITY] ? up_q : dn_q;
          pump_hiz_o  <= 1'b0;
        end
        default:
        begin
          pump_up_o   <= 1'b0;
          pump_down_o <= 1'b0;
          pump_hiz_o  <= 1'b1;   // holdover
        end
      endcase
    end
  end

  // checks
  sequence s_wait_req;
    req && waitrequest_o && bus_q == BUS_IDLE;
  endsequence

  sequence s_update_cmd;
    wr_go && idx == IDX_UPDATE && wbyte == UPDATE_CMD;
  endsequence

  bus_answer_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_wait_req |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not one cycle after request");

  update_copy_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_update_cmd |=> act_div_q == {$past(stg_hi_q[5:0]), $past(stg_lo_q)})
    else $error("update did not copy divider");

  no_update_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(wr_go && idx == IDX_UPDATE && wbyte == UPDATE_CMD) |=> $stable(act_div_q))
    else $error("divider changed without update");

  diff_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!loop_on || !diff_mode) |=> !diff_buf_en_o)
    else $error("differential buffer on when not allowed");

  single_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!loop_on || diff_mode) |=> !primary_buf_en_o && !secondary_buf_en_o)
    else $error("single-ended buffer on when not allowed");

  hold_block_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hold_q |=> !ref_div_tick)
    else $error("edge passed during deglitch hold");

  revert_pri_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (auto_on && !diff_mode && !act_ref_q[RC_PREF_SEC] && !ref_bad_q[0]) |=> !sel_sec_q)
    else $error("no revert to primary");

  div_held_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cnt_rst_q[CR_REF] [*2] |-> !ref_div_tick)
    else $error("divider ticked while held");

  hiz_mode_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    act_loop_q[LC_MODE_LSB +: 3] == PM_HIZ |=> pump_hiz_o && !pump_up_o && !pump_down_o)
    else $error("pump not high impedance");
endmodule : prd_ctrl

//--- bench/prd_ref_src.sv
// model of the two reference clock sources feeding the reference pins
`timescale 1ns/1ps
module prd_ref_src #(
  parameter int HALF = 8
)
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // run controls from the bench
  input  wire logic pri_run_i,
  input  wire logic sec_run_i,
  // reference levels
  output logic      pri_o,
  output logic      sec_o
);
  int cnt_q; // half period counter

  // a stopped source holds its level, as a dead oscillator would
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 0;
      pri_o <= 1'b0;
      sec_o <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (pri_run_i && cnt_q == HALF - 1)
        pri_o <= ~pri_o;
      if (sec_run_i && cnt_q == HALF / 2)
        sec_o <= ~sec_o;
    end
  end
endmodule : prd_ref_src

//--- bench/prd_ctrl_tb.sv
// self-checking bench for the reference control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module prd_ctrl_tb
  import prd_pkg::*;
;
  localparam int LOSS = 40; // shortened loss window, above one reference period
  localparam logic [9:0] RWI [6] = '{IDX_LOOP_CTRL, IDX_DIV_LOW, IDX_DIV_HIGH, IDX_DET_PULSE, IDX_MON_CFG,
                                     IDX_REF_CTRL};
  localparam logic [7:0] MSK [6] = '{8'hFF, 8'hFF, 8'h3F, 8'h03, 8'hFF, 8'hFF};
  localparam logic [7:0] LCT [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03};
  localparam logic [7:0] RCT [6] = '{8'h01, 8'h07, 8'h06, 8'h02, 8'h07, 8'h06};
  localparam logic [7:0] SLT [4] = '{8'h16, 8'h16, 8'h0E, 8'h06};
  // design inputs
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] address_i = 12'h000;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic        ref_select_i = 1'b0;
  logic        sync_i = 1'b0;
  logic        fb_div_tick_i = 1'b0;
  logic        pri_run = 1'b1;
  logic        sec_run = 1'b1;
  // design outputs and reference lines
  logic [31:0] readdata_o;
  logic        waitrequest_o, diff_buf_en_o, primary_buf_en_o, secondary_buf_en_o;
  logic        ref_monitor_out_o, status_out_o, pump_up_o, pump_down_o, pump_hiz_o, fb_counter_rst_o;
  logic [2:0]  pump_current_o;
  logic        pri_ref, sec_ref, ref_d;
  // bench state
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          edges = 0;
  int          e0, len;
  logic [31:0] q;
  logic [7:0]  v, lc, rc;
  logic [13:0] r;

  // clock and timeout
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // primary rising edges as the bench sees them
  always @(posedge clock_i)
  begin
    ref_d <= pri_ref;
    if (pri_ref && !ref_d)
      edges <= edges + 1;
  end

  prd_ref_src #(.HALF(8)) i_src (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pri_run_i(pri_run),
    .sec_run_i(sec_run), .pri_o(pri_ref), .sec_o(sec_ref));

  prd_ctrl #(.LOSS_CNT(LOSS)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .primary_reference_i(pri_ref), .secondary_reference_i(sec_ref),
    .ref_select_i(ref_select_i), .sync_i(sync_i), .fb_div_tick_i(fb_div_tick_i),
    .diff_buf_en_o(diff_buf_en_o), .primary_buf_en_o(primary_buf_en_o),
    .secondary_buf_en_o(secondary_buf_en_o), .ref_monitor_out_o(ref_monitor_out_o),
    .status_out_o(status_out_o), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o),
    .pump_hiz_o(pump_hiz_o), .pump_current_o(pump_current_o), .fb_counter_rst_o(fb_counter_rst_o));

  // expected buffer enables {diff, primary, secondary}
  function automatic logic [2:0] bufs(input logic [7:0] l, input logic [7:0] c);
    logic on;
    on = (l[1:0] == LC_PWR_ON);
    return {on & c[RC_DIFF], on & ~c[RC_DIFF] & c[RC_PRI_EN], on & ~c[RC_DIFF] & c[RC_SEC_EN]};
  endfunction : bufs
  // expected {up, down, hiz} for a forced or parked pump mode
  function automatic logic [2:0] pmode(input logic [2:0] m);
    return (m == PM_UP) ? 3'b100 : (m == PM_DOWN) ? 3'b010 : 3'b001;
  endfunction : pmode

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    address_i <= {idx, 2'b00};
    write_i <= wr;
    read_i <= ~wr;
    writedata_i <= {24'h0, d};
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 20);
    if (waitrequest_o !== 1'b0)
      n_mismatch++;
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
  endtask : settle

  // wait for a pump pin (0 up, 1 down) to reach a level
  task automatic wait_pin(input int k, input logic lvl);
    int n;
    n = 0;
    while (((k == 0) ? pump_up_o : pump_down_o) !== lvl && n < 400)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 400)
      n_mismatch++;
  endtask : wait_pin

  task automatic fb_pulse();
    fb_div_tick_i <= 1'b1;
    @(posedge clock_i);
    fb_div_tick_i <= 1'b0;
  endtask : fb_pulse

  task automatic summarize();
    $display("mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    void'($urandom(32'h92628622));
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    settle(2);
    `CHK("buffers", 3'b000, {diff_buf_en_o, primary_buf_en_o, secondary_buf_en_o})
    `CHK("pump pins", 3'b001, {pump_up_o, pump_down_o, pump_hiz_o})
    // reset values and readback of staged values
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, RWI[i], 8'h00);
      `CHK("reset value", 32'h0, q)
      v = 8'($urandom);
      bus(1'b1, RWI[i], v);
      bus(1'b0, RWI[i], 8'h00);
      `CHK("readback", v & MSK[i], q[7:0])
      `CHK("upper bits", 24'h0, q[31:8])
    end
    bus(1'b1, 10'h100, 8'hA5);
    bus(1'b0, 10'h100, 8'h00);
    `CHK("unmapped", 32'h0, q)
    // buffer power table, then random control values
    for (int i = 0; i < 10; i++)
    begin
      lc = (i < 6) ? LCT[i] : {6'h0, 2'($urandom_range(0, 3))};
      rc = (i < 6) ? RCT[i] : 8'($urandom);
      bus(1'b1, IDX_LOOP_CTRL, lc);
      bus(1'b1, IDX_REF_CTRL, rc);
      settle(3);
      if (i == 0)
        `CHK("staged", 3'b000, {diff_buf_en_o, primary_buf_en_o, secondary_buf_en_o})
      bus(1'b1, IDX_UPDATE, UPDATE_CMD);
      settle(3);
      `CHK("buffers", bufs(lc, rc), {diff_buf_en_o, primary_buf_en_o, secondary_buf_en_o})
    end
    // every current step, and every pump mode code but normal
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, IDX_PUMP_CUR, 8'(i));
      bus(1'b1, IDX_LOOP_CTRL, {1'b0, 3'(i), 4'h0});
      bus(1'b1, IDX_UPDATE, UPDATE_CMD);
      settle(3);
      `CHK("pump current", 3'(i), pump_current_o)
      if (i != 3)
        `CHK("pump pins", pmode(3'(i)), {pump_up_o, pump_down_o, pump_hiz_o})
    end
    // counter reset bits hold until cleared; sync resets when enabled
    bus(1'b1, IDX_CNT_RST, 8'h02);
    settle(20);
    `CHK("shared reset", 1'b1, fb_counter_rst_o)
    bus(1'b1, IDX_CNT_RST, 8'h04);
    settle(2);
    `CHK("shared reset", 1'b0, fb_counter_rst_o)
    sync_i <= 1'b1;
    settle(3);
    `CHK("sync reset", 1'b1, fb_counter_rst_o)
    sync_i <= 1'b0;
    // divider ratio and antibacklash width, seen through the pump in normal mode
    bus(1'b1, IDX_REF_CTRL, 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 14'd0 : (i == 1) ? 14'd1 : (i == 2) ? 14'd3 : 14'($urandom_range(2, 9));
      bus(1'b1, IDX_DIV_LOW, r[7:0]);
      bus(1'b1, IDX_DIV_HIGH, {2'b00, r[13:8]});
      bus(1'b1, IDX_DET_PULSE, 8'(i));
      bus(1'b1, IDX_LOOP_CTRL, 8'h30);
      bus(1'b1, IDX_UPDATE, UPDATE_CMD);
      bus(1'b1, IDX_CNT_RST, 8'h01);
      bus(1'b1, IDX_CNT_RST, 8'h00);
      // drop a stale tick, then count edges between two fresh ticks
      wait_pin(0, 1'b1);
      fb_pulse();
      wait_pin(0, 1'b0);
      wait_pin(0, 1'b1);
      e0 = edges;
      fb_pulse();
      wait_pin(0, 1'b0);
      wait_pin(0, 1'b1);
      `CHK("edges per tick", (r < 2) ? 1 : int'(r), edges - e0)
      fb_pulse();
      wait_pin(1, 1'b1);
      len = 0;
      while (pump_down_o === 1'b1 && len < 50)
      begin
        @(posedge clock_i);
        len++;
      end
      `CHK("pulse width", (i + 1) * ABL_STEP_CYC + 1, len)
    end
    // negative polarity: a reference tick drives the down pin
    bus(1'b1, IDX_LOOP_CTRL, 8'hB0);
    bus(1'b1, IDX_UPDATE, UPDATE_CMD);
    wait_pin(1, 1'b1);
    `CHK("polarity", 1'b0, pump_up_o)
    fb_pulse();
    // automatic revertive switching on primary loss
    bus(1'b1, IDX_MON_CFG, 8'hF7);
    bus(1'b1, IDX_REF_CTRL, 8'h26);
    bus(1'b1, IDX_UPDATE, UPDATE_CMD);
    settle(LOSS);
    `CHK("monitor", 1'b0, ref_monitor_out_o)
    pri_run <= 1'b0;
    settle(LOSS + 40);
    `CHK("monitor", 1'b1, ref_monitor_out_o)
    `CHK("secondary selected", 1'b1, status_out_o)
    pri_run <= 1'b1;
    settle(40);
    `CHK("monitor", 1'b0, ref_monitor_out_o)
    `CHK("secondary selected", 1'b0, status_out_o)
    // secondary preferred, status pin carries the selection
    bus(1'b1, IDX_MON_CFG, 8'hF8);
    bus(1'b1, IDX_REF_CTRL, 8'h66);
    bus(1'b1, IDX_UPDATE, UPDATE_CMD);
    settle(LOSS);
    `CHK("secondary selected", 1'b1, status_out_o)
    sec_run <= 1'b0;
    settle(LOSS + 40);
    `CHK("monitor", 1'b1, ref_monitor_out_o)
    `CHK("secondary selected", 1'b0, status_out_o)
    sec_run <= 1'b1;
    settle(40);
    `CHK("secondary selected", 1'b1, status_out_o)
    // manual selection by pin and by register
    for (int i = 0; i < 4; i++)
    begin
      ref_select_i <= (i == 0 || i == 3);
      bus(1'b1, IDX_REF_CTRL, SLT[i]);
      bus(1'b1, IDX_UPDATE, UPDATE_CMD);
      settle(40);
      `CHK("manual select", (i == 0 || i == 2), status_out_o)
    end
    // switch to a silent reference: deglitch holds until it toggles
    sec_run <= 1'b0;
    bus(1'b1, IDX_REF_CTRL, 8'h0E);
    bus(1'b1, IDX_UPDATE, UPDATE_CMD);
    settle(LOSS);
    bus(1'b0, IDX_STATUS, 8'h00);
    `CHK("deglitch hold", 1'b1, q[3])
    sec_run <= 1'b1;
    settle(40);
    bus(1'b0, IDX_STATUS, 8'h00);
    `CHK("deglitch hold", 1'b0, q[3])
    summarize();
  end
endmodule : prd_ctrl_tb
